// [rsec_pkg.sv]
package rsec_pkg;

  localparam int NUM_PORTS = 16;
  localparam int CNT_NUM   = 5;
  localparam int AXI_AW    = 16;

  // Register indices inside one port window; byte address is index * 4
  localparam logic [8:0] OFF_MW_EN0   = 9'h03c;
  localparam logic [8:0] OFF_MW_EN2   = 9'h03e;
  localparam logic [8:0] OFF_SIG_FIRST = 9'h040;
  localparam logic [8:0] OFF_SIG_LAST = 9'h04f;
  localparam logic [8:0] OFF_LCV_HI   = 9'h050;
  localparam logic [8:0] OFF_LCV_LO   = 9'h051;
  localparam logic [8:0] OFF_PCV_HI   = 9'h052;
  localparam logic [8:0] OFF_PCV_LO   = 9'h053;
  localparam logic [8:0] OFF_UNSYNC_HI = 9'h054;
  localparam logic [8:0] OFF_UNSYNC_LO = 9'h055;
  localparam logic [8:0] OFF_EBIT_HI  = 9'h056;
  localparam logic [8:0] OFF_EBIT_LO  = 9'h057;
  localparam logic [8:0] OFF_FEA_HI   = 9'h058;
  localparam logic [8:0] OFF_FEA_LO   = 9'h059;
  localparam logic [8:0] OFF_MODE     = 9'h05c;

  // Port window spacing, in register indices
  localparam logic [13:0] PORT_STRIDE  = 14'h0200;
  localparam logic [13:0] GROUP_STRIDE = 14'h2000;
  localparam int          PORTS_PER_GROUP = 8;

  // Mode register fields and reset values
  localparam int         MODE_E1_BIT  = 0;
  localparam int         MODE_ESF_BIT = 1;
  localparam logic [1:0] MODE_RESET   = 2'h0;
  localparam logic [7:0] BYTE_RESET   = 8'h00;
  localparam logic [15:0] CNT_RESET   = 16'h0000;
  localparam logic [15:0] CNT_MAX     = 16'hffff;

  // Counter slots
  localparam int CNT_LCV    = 0;
  localparam int CNT_PCV    = 1;
  localparam int CNT_UNSYNC = 2;
  localparam int CNT_EBIT   = 3;
  localparam int CNT_FEA    = 4;

  // Channel ranges
  localparam logic [4:0] T1_HALF  = 5'h0c;
  localparam logic [4:0] T1_LAST  = 5'h18;
  localparam logic [4:0] E1_HALF  = 5'h0f;
  localparam logic [4:0] E1_LAST  = 5'h1e;
  localparam logic [4:0] MW_LAST  = 5'h18;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Digital milliwatt sequence, one byte per frame
  localparam logic [7:0] MW_CODE [8] = '{8'h1e, 8'h0b, 8'h0b, 8'h1e,
                                        8'h9e, 8'h8b, 8'h8b, 8'h9e};

  typedef struct packed {
    logic       frameStart;
    logic       chanValid;
    logic [4:0] chanNum;
    logic [7:0] chanData;
    logic       sigValid;
    logic [4:0] sigChan;
    logic [3:0] sigBits;
    logic       oof;
    logic       lcvPulse;
    logic       pcvPulse;
    logic       unsyncPulse;
    logic       ebitPulse;
    logic       feaPulse;
  } rsec_rxin_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] chanNum;
    logic [7:0] data;
  } rsec_rxout_t;

  typedef struct packed {
    logic       ok;
    logic [3:0] port;
    logic [8:0] off;
  } rsec_dec_t;

  function automatic rsec_dec_t rsec_decode(input logic [AXI_AW-1:0] addr);
    rsec_dec_t  d;
    logic [13:0] idx;
    idx    = addr[AXI_AW-1:2];
    d.port = {idx[13], idx[11:9]};
    d.off  = idx[8:0];
    d.ok   = (idx[13] == idx[12]);
    return d;
  endfunction : rsec_decode

  function automatic logic rsec_mapped(input logic [8:0] off);
    return (off >= OFF_MW_EN0 && off <= OFF_MW_EN2) ||
           (off >= OFF_SIG_FIRST && off <= OFF_FEA_LO) || (off == OFF_MODE);
  endfunction : rsec_mapped

  function automatic logic rsec_writable(input logic [8:0] off);
    return (off >= OFF_MW_EN0 && off <= OFF_MW_EN2) || (off == OFF_MODE);
  endfunction : rsec_writable

endpackage : rsec_pkg

// [rsec_top.sv]
// Function
// - Enabled channel receive data replaced by milliwatt
// - Two channels per signaling byte, T1/E1 layouts
// - Per-port window at 200h and 2000h strides
// - ESF captures all four ABCD bits
// - D4 copies A,B into C,D
// - Signaling frozen while sync is lost
// - Line code violation count at 050h/051h
// - Path code violation count at 052h/053h
// - Frames out of sync count at 054h/055h
// - E-bit count in E1 only, 056h/057h
// - Far-end count A high byte at 058h
// - Far-end count A low byte at 059h
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module rsec_port
  import rsec_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Receive side
  input  wire rsec_rxin_t  rxIn,
  output rsec_rxout_t      rxOut,
  // Register access
  input  wire logic        wrEn,
  input  wire logic [8:0]  wrOff,
  input  wire logic [7:0]  wrData,
  input  wire logic        rdEn,
  input  wire logic [8:0]  rdOff,
  output logic [7:0]       rdByte
);

  logic [2:0][7:0]          mwEn_reg;
  logic [1:0]               mode_reg;
  logic [15:0][7:0]         sig_reg;
  logic [CNT_NUM-1:0][15:0] cnt_reg;
  logic [CNT_NUM-1:0][7:0]  snap_reg;
  logic [2:0]               mwPhase_reg;
  logic [CNT_NUM-1:0]       cntEvent;
  logic [23:0]              mwFlat;
  logic                     mwHit;
  logic                     isE1;
  logic                     isEsf;
  logic [3:0]               sigNib;
  logic [3:0]               sigIdx;
  logic                     sigHigh;
  logic                     sigOk;
  logic [8:0]               cntOff;
  logic [2:0]               cntSel;
  logic                     mwSub;
  logic                     sigWr;
  logic                     cntHit;
  logic                     cntSnap;

  assign isE1  = mode_reg[MODE_E1_BIT];
  assign isEsf = mode_reg[MODE_ESF_BIT];
  assign mwFlat = {mwEn_reg[2], mwEn_reg[1], mwEn_reg[0]};

  //////////////////////////////////////////////////////////////////////////////
  // Software-written controls
  // Milliwatt enables apply in E1 too; no bit exists past channel 24
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mwEn_reg <= '0;
      mode_reg <= MODE_RESET;
    end else if (wrEn) begin
      if (wrOff == OFF_MODE) begin
        mode_reg <= wrData[1:0];
      end else if (wrOff >= OFF_MW_EN0 && wrOff <= OFF_MW_EN2) begin
        mwEn_reg[wrOff[1:0]] <= wrData;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive data path with milliwatt substitution
  always_comb begin
    mwHit = 1'b0;
    if (rxIn.chanNum != 5'h00 && rxIn.chanNum <= MW_LAST) begin
      mwHit = mwFlat[rxIn.chanNum - 5'h01];
    end
  end

  assign mwSub = rxIn.chanValid && mwHit;

  // The phase runs free on frame starts, so a channel enabled mid-run
  // picks up the table wherever it stands
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mwPhase_reg <= 3'h0;
    end else if (rxIn.frameStart) begin
      mwPhase_reg <= mwPhase_reg + 3'h1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rxOut <= '0;
    end else begin
      rxOut.valid   <= rxIn.chanValid;
      rxOut.chanNum <= rxIn.chanNum;
      rxOut.data    <= mwSub ? MW_CODE[mwPhase_reg] : rxIn.chanData;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Signaling capture
  // E1 always carries four bits; the superframe bit matters in T1 only
  always_comb begin
    sigNib  = isEsf || isE1 ? rxIn.sigBits
                            : {rxIn.sigBits[3:2], rxIn.sigBits[3:2]};
    sigIdx  = 4'h0;
    sigHigh = 1'b0;
    sigOk   = 1'b0;
    if (isE1) begin
      // Channel 0 carries the X/Y spare bits into the low nibble of byte 0
      if (rxIn.sigChan == 5'h00) begin
        sigOk = 1'b1;
      end else if (rxIn.sigChan <= E1_HALF) begin
        sigIdx  = rxIn.sigChan[3:0];
        sigHigh = 1'b1;
        sigOk   = 1'b1;
      end else if (rxIn.sigChan <= E1_LAST) begin
        sigIdx = 4'((rxIn.sigChan - E1_HALF));
        sigOk  = 1'b1;
      end
    end else if (rxIn.sigChan != 5'h00) begin
      if (rxIn.sigChan <= T1_HALF) begin
        sigIdx  = 4'((rxIn.sigChan - 5'h01));
        sigHigh = 1'b1;
        sigOk   = 1'b1;
      end else if (rxIn.sigChan <= T1_LAST) begin
        sigIdx = 4'((rxIn.sigChan - T1_HALF - 5'h01));
        sigOk  = 1'b1;
      end
    end
  end

  // Updates are dropped, not queued, while sync is lost, so the host keeps
  // the last values taken in frame
  assign sigWr = rxIn.sigValid && sigOk && !rxIn.oof;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sig_reg <= '0;
    end else if (sigWr) begin
      if (sigHigh) begin
        sig_reg[sigIdx][7:4] <= sigNib;
      end else begin
        sig_reg[sigIdx][3:0] <= sigNib;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Performance counters; they saturate so a long gap between reads never
  // shows a small wrapped value
  // Nothing clears them but reset; no register write reaches them
  assign cntEvent[CNT_LCV]  = rxIn.lcvPulse;
  assign cntEvent[CNT_PCV]  = rxIn.pcvPulse;
  assign cntEvent[CNT_UNSYNC] = rxIn.unsyncPulse;
  assign cntEvent[CNT_EBIT] = rxIn.ebitPulse && isE1;
  assign cntEvent[CNT_FEA]  = rxIn.feaPulse;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= {CNT_NUM{CNT_RESET}};
    end else begin
      for (int i = 0; i < CNT_NUM; i++) begin
        if (cntEvent[i] && cnt_reg[i] != CNT_MAX) begin
          cnt_reg[i] <= cnt_reg[i] + 16'h0001;
        end
      end
    end
  end

  assign cntOff  = rdOff - OFF_LCV_HI;
  assign cntSel  = cntOff[3:1];
  assign cntHit  = rdOff >= OFF_LCV_HI && rdOff <= OFF_FEA_LO;
  assign cntSnap = rdEn && cntHit && !rdOff[0];

  // Reading the upper byte freezes the lower byte for the following read;
  // a lower-byte read with no upper-byte read before it gets an old value
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      snap_reg <= '0;
    end else if (cntSnap) begin
      snap_reg[cntSel] <= cnt_reg[cntSel][7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read multiplexer
  always_comb begin
    rdByte = BYTE_RESET;
    if (rdOff >= OFF_MW_EN0 && rdOff <= OFF_MW_EN2) begin
      rdByte = mwEn_reg[rdOff[1:0]];
    end else if (rdOff >= OFF_SIG_FIRST && rdOff <= OFF_SIG_LAST) begin
      rdByte = sig_reg[rdOff[3:0]];
    end else if (cntHit) begin
      rdByte = rdOff[0] ? snap_reg[cntSel]
                        : cnt_reg[cntSel][15:8];
    end else if (rdOff == OFF_MODE) begin
      rdByte = {6'h00, mode_reg};
    end
  end

endmodule : rsec_port

////////////////////////////////////////////////////////////////////////////////
module rsec_top
  import rsec_pkg::*;
(
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          arst_n,
  // AXI4-Lite write address
  input  wire logic [AXI_AW-1:0]             s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [AXI_AW-1:0]             s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Per-port receive streams
  input  wire rsec_rxin_t [NUM_PORTS-1:0]    rxIn,
  output rsec_rxout_t [NUM_PORTS-1:0]        rxOut
);

  logic [AXI_AW-1:0]          awAddr_reg;
  logic                       awHave_reg;
  logic [7:0]                 wByte_reg;
  logic                       wLane0_reg;
  logic                       wHave_reg;
  logic                       doWrite;
  logic                       arTake;
  rsec_dec_t                  wDec;
  rsec_dec_t                  rDec;
  logic [NUM_PORTS-1:0][7:0]  portByte;
  logic                       wrGo;
  logic                       rdGo;
  logic                       wrMapped;
  logic                       rdMapped;

  assign wDec    = rsec_decode(awAddr_reg);
  assign rDec    = rsec_decode(s_axi_araddr);
  assign doWrite = awHave_reg && wHave_reg && !s_axi_bvalid;
  assign arTake  = s_axi_arvalid && s_axi_arready;
  assign wrMapped = wDec.ok && rsec_mapped(wDec.off);
  assign rdMapped = rDec.ok && rsec_mapped(rDec.off);
  // Writes to read-only and unmapped offsets never reach a port; only the response
  // code tells software whether the offset exists
  assign wrGo     = doWrite && wLane0_reg && wDec.ok
                    && rsec_writable(wDec.off);
  assign rdGo     = arTake && rDec.ok;

  //////////////////////////////////////////////////////////////////////////////
  // Write channels; address and data are taken in either order and the
  // ready stays low until the response is accepted, so one write at a time
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      awHave_reg    <= 1'b0;
      awAddr_reg    <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_reg    <= s_axi_awaddr;
        awHave_reg    <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (doWrite) begin
        awHave_reg <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_wready <= 1'b1;
      wHave_reg    <= 1'b0;
      wByte_reg    <= BYTE_RESET;
      wLane0_reg   <= 1'b0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        wByte_reg    <= s_axi_wdata[7:0];
        wLane0_reg   <= s_axi_wstrb[0];
        wHave_reg    <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (doWrite) begin
        wHave_reg <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read channels; data is registered at the address handshake
  // so a counter event in that same cycle shows on the next read
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (arTake) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      if (rdMapped) begin
        s_axi_rdata <= {24'h00_0000, portByte[rDec.port]};
        s_axi_rresp <= RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sixteen identical port banks
  for (genvar p = 0; p < NUM_PORTS; p++) begin : gPort
    rsec_port uPort (
      .clock  (clock),
      .arst_n (arst_n),
      .rxIn   (rxIn[p]),
      .rxOut  (rxOut[p]),
      .wrEn   (wrGo && wDec.port == 4'(p)),
      .wrOff  (wDec.off),
      .wrData (wByte_reg),
      .rdEn   (rdGo && rDec.port == 4'(p)),
      .rdOff  (rDec.off),
      .rdByte (portByte[p])
    );
  end

endmodule : rsec_top

// [rsec_top_assertions.sv]
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module rsec_top_chk
  import rsec_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Register bus
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Receive streams
  input wire rsec_rxin_t [NUM_PORTS-1:0] rxIn,
  input wire rsec_rxout_t [NUM_PORTS-1:0] rxOut
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  property p_bwait;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_bwait: assert property (p_bwait)
    else $error("aw taken during response");
  property p_bans;
    s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_bans: assert property (p_bans)
    else $error("write response missing");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("bvalid dropped early");
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rans: assert property (p_rans)
    else $error("read answer late");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data moved");
  property p_rbyte;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rbyte: assert property (p_rbyte)
    else $error("upper read bits set");
  // Window holes: index bit 13 differs from bit 12
  property p_rbad;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr[15] != s_axi_araddr[14])
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_rbad: assert property (p_rbad)
    else $error("hole not refused");
  property p_rxlat;
    rxIn[0].chanValid |=> rxOut[0].valid
      && rxOut[0].chanNum == $past(rxIn[0].chanNum);
  endproperty
  a_rxlat: assert property (p_rxlat)
    else $error("receive byte lost");
endmodule : rsec_top_chk

bind rsec_top rsec_top_chk chk_u (.*);

// [rsec_host.sv]
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module rsec_host
  import rsec_pkg::*;
(
  // Clock
  input wire logic clock,
  // Write side
  output logic [AXI_AW-1:0]  s_axi_awaddr,
  output logic               s_axi_awvalid,
  input wire logic           s_axi_awready,
  output logic [31:0]        s_axi_wdata,
  output logic [3:0]         s_axi_wstrb,
  output logic               s_axi_wvalid,
  input wire logic           s_axi_wready,
  input wire logic [1:0]     s_axi_bresp,
  input wire logic           s_axi_bvalid,
  output logic               s_axi_bready,
  // Read side
  output logic [AXI_AW-1:0]  s_axi_araddr,
  output logic               s_axi_arvalid,
  input wire logic           s_axi_arready,
  input wire logic [31:0]    s_axi_rdata,
  input wire logic [1:0]     s_axi_rresp,
  input wire logic           s_axi_rvalid,
  output logic               s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end

  task automatic wr(input logic [15:0] a, input logic [7:0] v,
                    output logic [1:0] r);
    logic aw, w;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge clock);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~{24'h0, v};
      end
    end
    do @(posedge clock); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  // Reads come far more often than the signaling refresh needs
  task automatic rd(input logic [15:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    // Ready comes a cycle late so the slave must hold its answer
    @(posedge clock);
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : rsec_host

// [tb_top.sv]
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module tb_top
  import rsec_pkg::*;
();
  typedef struct {
    int          port;
    int          slot;
    int          n;
    logic [8:0]  off;
    logic [15:0] exp;
  } rsec_row_t;

  logic                   clock = 1'b0;
  logic                   arst_n;
  logic [AXI_AW-1:0]      s_axi_awaddr, s_axi_araddr;
  logic [2:0]             s_axi_awprot = 3'h0;
  logic [2:0]             s_axi_arprot = 3'h0;
  logic [31:0]            s_axi_wdata, s_axi_rdata;
  logic [3:0]             s_axi_wstrb;
  logic [1:0]             s_axi_bresp, s_axi_rresp;
  logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                   s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                   s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic                   s_axi_rready;
  rsec_rxin_t [NUM_PORTS-1:0]  rxIn;
  rsec_rxout_t [NUM_PORTS-1:0] rxOut;
  logic [31:0]            d;
  logic [1:0]             r;
  int                     failures = 0;
  int                     samples_checked = 0;
  int                     cyc = 0;

  // Second row crosses into the high byte; row 5 is E-bits in T1 mode
  rsec_row_t rows [6] = '{
    '{1, CNT_LCV, 3, OFF_LCV_HI, 16'h0003},
    '{8, CNT_PCV, 261, OFF_PCV_HI, 16'h0105},
    '{9, CNT_UNSYNC, 2, OFF_UNSYNC_HI, 16'h0002},
    '{16, CNT_FEA, 258, OFF_FEA_HI, 16'h0102},
    '{2, CNT_EBIT, 4, OFF_EBIT_HI, 16'h0000},
    '{16, CNT_LCV, 1, OFF_LCV_HI, 16'h0001}};

  rsec_top  dut_u (.*);
  rsec_host host_u (.*);

  always #25 clock = ~clock;

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end

  function automatic logic [15:0] adr(input int p, input logic [8:0] o);
    return 16'((int'(o) + 'h200 * (p - 1) + 'h2000 * ((p - 1) / 8)) * 4);
  endfunction : adr

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic rc(input int p, input logic [8:0] o, input logic [7:0] e);
    host_u.rd(adr(p, o), d, r);
    chk(d, {24'h0, e});
  endtask : rc

  task automatic wt(input int p, input logic [8:0] o, input logic [7:0] v);
    host_u.wr(adr(p, o), v, r);
  endtask : wt

  task automatic ev(input int p, input int s, input logic v);
    case (s)
      CNT_LCV: rxIn[p].lcvPulse <= v;
      CNT_PCV: rxIn[p].pcvPulse <= v;
      CNT_UNSYNC: rxIn[p].unsyncPulse <= v;
      CNT_EBIT: rxIn[p].ebitPulse <= v;
      default: rxIn[p].feaPulse <= v;
    endcase
  endtask : ev

  // A level held n cycles counts n events
  task automatic pulse(input int p, input int s, input int n);
    @(posedge clock);
    ev(p, s, 1'b1);
    repeat (n) @(posedge clock);
    ev(p, s, 1'b0);
  endtask : pulse

  task automatic sig(input int p, input logic [4:0] c, input logic [3:0] b);
    @(posedge clock);
    rxIn[p].sigValid <= 1'b1;
    rxIn[p].sigChan <= c;
    rxIn[p].sigBits <= b;
    @(posedge clock);
    rxIn[p].sigValid <= 1'b0;
  endtask : sig

  task automatic chan(input logic [4:0] c, input logic [7:0] e);
    @(posedge clock);
    rxIn[0].chanValid <= 1'b1;
    rxIn[0].chanNum <= c;
    rxIn[0].chanData <= 8'h55;
    @(posedge clock);
    rxIn[0].chanValid <= 1'b0;
    @(negedge clock);
    chk({24'h0, rxOut[0].data}, {24'h0, e});
  endtask : chan

  task automatic results;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  initial begin
    arst_n = 1'b0;
    rxIn = '0;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      pulse(rows[i].port - 1, rows[i].slot, rows[i].n);
      rc(rows[i].port, rows[i].off, rows[i].exp[15:8]);
      rc(rows[i].port, rows[i].off + 9'h1, rows[i].exp[7:0]);
    end
    $display("counter table done");
    rc(1, OFF_LCV_HI, 8'h00);
    pulse(0, CNT_LCV, 1);
    rc(1, OFF_LCV_LO, 8'h03);
    rc(1, OFF_LCV_HI, 8'h00);
    rc(1, OFF_LCV_LO, 8'h04);
    $display("snapshot done");
    sig(0, 5'h01, 4'hb);
    sig(0, 5'h0d, 4'h6);
    rc(1, OFF_SIG_FIRST, 8'ha5);
    wt(1, OFF_MODE, 8'h02);
    sig(0, 5'h18, 4'hc);
    rc(1, 9'h04b, 8'h0c);
    rxIn[0].oof <= 1'b1;
    sig(0, 5'h18, 4'h3);
    rc(1, 9'h04b, 8'h0c);
    rxIn[0].oof <= 1'b0;
    wt(5, OFF_MODE, 8'h01);
    sig(4, 5'h00, 4'h9);
    sig(4, 5'h0f, 4'he);
    sig(4, 5'h1e, 4'h7);
    rc(5, OFF_SIG_FIRST, 8'h09);
    rc(5, OFF_SIG_LAST, 8'he7);
    pulse(4, CNT_EBIT, 2);
    rc(5, OFF_EBIT_HI, 8'h00);
    rc(5, OFF_EBIT_LO, 8'h02);
    $display("signaling done");
    wt(1, OFF_MW_EN0, 8'h01);
    chan(5'h01, MW_CODE[0]);
    chan(5'h02, 8'h55);
    @(posedge clock);
    rxIn[0].frameStart <= 1'b1;
    @(posedge clock);
    rxIn[0].frameStart <= 1'b0;
    chan(5'h01, MW_CODE[1]);
    $display("milliwatt done");
    host_u.rd(16'h4000, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    host_u.rd(adr(1, 9'h070), d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wt(1, OFF_LCV_HI, 8'hff);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rc(1, OFF_LCV_HI, 8'h00);
    rc(1, OFF_LCV_LO, 8'h04);
    $display("refusals done");
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    for (int o = OFF_LCV_HI; o <= OFF_FEA_LO; o++)
      rc(16, 9'(o), 8'h00);
    $display("reset done");
    results();
  end
endmodule : tb_top
